// ---- rtl/psil_top.sv ----
// Our own choice: the AHB-Lite interface to the registers.
`timescale 1ns/10ps
`default_nettype none
`include "psil_defs.svh"

module psil_top (
	input  wire logic                core_clk,
	input  wire logic                srst,
	input  wire logic                hsel,
	input  wire logic [31:0]         haddr,
	input  wire logic [1:0]          htrans,
	input  wire logic                hwrite,
	input  wire logic [2:0]          hsize,
	input  wire logic [31:0]         hwdata,
	input  wire logic                hready,
	output logic                     hreadyout,
	output logic                     hresp,
	output logic      [31:0]         hrdata,
	input  wire psil_pkg::psil_src_s  src_raw,
	input  wire psil_pkg::psil_slew_s slew_raw,
	output logic                     status_out_a,
	output logic                     status_out_a_oe,
	output logic                     status_out_b,
	output logic                     status_out_b_oe,
	output logic                     status_out_a_spike_limit,
	output logic                     status_out_b_spike_limit,
	output logic                     irq
);
	import psil_pkg::*;

	psil_req_s  req;
	logic [31:0] rdata;
	logic [7:0]  src_sync;
	logic [3:0]  slew_sync;
	psil_byte_t  src_live;
	psil_byte_t  slew_word;
	psil_byte_t  wdata8;
	psil_byte_t  edge_hit;
	psil_byte_t  flag_set;
	psil_byte_t  flag_clr;
	psil_byte_t  act_or;
	logic        en;
	logic        and_mode;
	logic        or_int;
	logic        and_int;
	logic        int_now;
	logic        flag_wr;
	logic        pin_a_level;

	psil_byte_t  prev_ff;
	psil_byte_t  nxt_prev;
	logic [3:0]  slew_prev_ff;
	logic [3:0]  nxt_slew_prev;
	logic [2:0]  primed_ff;
	logic [2:0]  nxt_primed;
	logic        primed;
	psil_byte_t  flags_ff;
	psil_byte_t  nxt_flags;
	psil_byte_t  mask_ff;
	psil_byte_t  nxt_mask;
	psil_byte_t  pol_ff;
	psil_byte_t  nxt_pol;
	psil_byte_t  ctl_ff;
	psil_byte_t  nxt_ctl;
	psil_byte_t  stat_ff;
	psil_byte_t  nxt_stat;
	logic        int_ff;
	logic        nxt_int;
	psil_byte_t  irq_stat_ff;
	psil_byte_t  nxt_irq_stat;
	psil_byte_t  irq_mask_ff;
	psil_byte_t  nxt_irq_mask;
	logic        irq_ff;
	logic        nxt_irq;

	// ****************************************************************
	// Bus front end and input synchronisers
	// ****************************************************************
	psil_ahb_slave u_bus (
		.core_clk  (core_clk),
		.srst      (srst),
		.hsel      (hsel),
		.haddr     (haddr),
		.htrans    (htrans),
		.hwrite    (hwrite),
		.hsize     (hsize),
		.hwdata    (hwdata),
		.hready    (hready),
		.hreadyout (hreadyout),
		.hresp     (hresp),
		.hrdata    (hrdata),
		.req       (req),
		.rdata     (rdata)
	);

	psil_sync #(.WIDTH(8)) u_src_sync (
		.core_clk (core_clk),
		.srst     (srst),
		.d        (src_raw),
		.q        (src_sync)
	);

	psil_sync #(.WIDTH(4)) u_slew_sync (
		.core_clk (core_clk),
		.srst     (srst),
		.d        (slew_raw),
		.q        (slew_sync)
	);

	// ****************************************************************
	// Source view, edge detection, flags
	// ****************************************************************
	assign en       = ctl_ff[`PSIL_CTL_EN_BIT];
	assign and_mode = ctl_ff[`PSIL_CTL_AND_BIT];
	assign wdata8   = req.wdata[7:0];
	assign flag_wr  = req.valid && req.write && (req.index == `PSIL_IDX_FLAGS);

	always_comb begin
		src_live = src_sync;
		// Input loss hides the lock loss it causes
		src_live[`PSIL_SRC_LOL_A] = src_sync[`PSIL_SRC_LOL_A] &&
			!src_sync[`PSIL_SRC_LOS_A];
		src_live[`PSIL_SRC_LOL_B] = src_sync[`PSIL_SRC_LOL_B] &&
			!src_sync[`PSIL_SRC_LOS_B];
	end

	// Edges count only once the synchronisers and the previous samples
	// hold real input, so a source idling high gives no edge after reset
	assign primed = primed_ff[2];

	always_comb begin
		nxt_prev      = src_live;
		nxt_slew_prev = slew_sync;
		nxt_primed    = {primed_ff[1:0], 1'b1};
		// Changed bit whose new level equals its polarity
		edge_hit = primed ? ((src_live ^ prev_ff) & ~(src_live ^ pol_ff))
			: `PSIL_RST_BYTE;
		flag_set = en ? edge_hit : `PSIL_RST_BYTE;
		flag_clr = flag_wr ? ~wdata8 : `PSIL_RST_BYTE;
		nxt_flags = (flags_ff & ~flag_clr) | flag_set;
	end

	// ****************************************************************
	// Combination onto the status pins
	// ****************************************************************
	assign act_or  = flags_ff & ~mask_ff;
	assign or_int  = |act_or;
	assign and_int = (mask_ff != `PSIL_ALL_ONES) &&
		((flags_ff | mask_ff) == `PSIL_ALL_ONES);
	assign int_now = en && (and_mode ? and_int : or_int);
	assign nxt_int = int_now;

	// Open drain releases the pin when active, drives low when idle
	always_comb begin
		status_out_a    = stat_ff[`PSIL_STAT_OD_A] ? 1'b0 : int_ff;
		status_out_a_oe = stat_ff[`PSIL_STAT_OD_A] ? !int_ff : 1'b1;
		status_out_b    = stat_ff[`PSIL_STAT_OD_B] ? 1'b0 : int_ff;
		status_out_b_oe = stat_ff[`PSIL_STAT_OD_B] ? !int_ff : 1'b1;
	end

	assign status_out_a_spike_limit = stat_ff[`PSIL_STAT_SL_A];
	assign status_out_b_spike_limit = stat_ff[`PSIL_STAT_SL_B];
	assign pin_a_level = status_out_a_oe ? status_out_a : 1'b1;

	// ****************************************************************
	// Register writes, read mux, sticky interrupt status
	// ****************************************************************
	always_comb begin
		nxt_mask     = mask_ff;
		nxt_pol      = pol_ff;
		nxt_ctl      = ctl_ff;
		nxt_stat     = stat_ff;
		nxt_irq_mask = irq_mask_ff;
		if (req.valid && req.write) begin
			case (req.index)
				`PSIL_IDX_MASK:     nxt_mask = wdata8;
				`PSIL_IDX_POL:      nxt_pol  = wdata8;
				`PSIL_IDX_CTL:      nxt_ctl  = wdata8 & `PSIL_CTL_RW_MASK;
				`PSIL_IDX_STAT:     nxt_stat = wdata8 & `PSIL_STAT_RW_MASK;
				`PSIL_IDX_IRQ_MASK: nxt_irq_mask = wdata8 & `PSIL_IRQ_RW_MASK;
				default:            nxt_mask = mask_ff;
			endcase
		end
	end

	assign slew_word = {slew_sync, 4'h0};

	always_comb begin
		rdata = 32'h0000_0000;
		case (req.index)
			`PSIL_IDX_LIVE:     rdata[7:0] = src_live;
			`PSIL_IDX_MASK:     rdata[7:0] = mask_ff;
			`PSIL_IDX_POL:      rdata[7:0] = pol_ff;
			`PSIL_IDX_FLAGS:    rdata[7:0] = flags_ff;
			`PSIL_IDX_CTL:      rdata[7:0] = ctl_ff;
			`PSIL_IDX_SLEW:     rdata[7:0] = slew_word;
			`PSIL_IDX_STAT:     rdata[7:0] = stat_ff;
			`PSIL_IDX_IRQ_STAT: rdata[7:0] = irq_stat_ff;
			`PSIL_IDX_IRQ_MASK: rdata[7:0] = irq_mask_ff;
			default:            rdata = 32'h0000_0000;
		endcase
	end

	// Read clears, a new event in the same cycle still sets
	always_comb begin
		nxt_irq_stat = irq_stat_ff;
		if (req.valid && !req.write && (req.index == `PSIL_IDX_IRQ_STAT)) begin
			nxt_irq_stat = `PSIL_RST_BYTE;
		end
		if (int_now && !int_ff) begin
			nxt_irq_stat[`PSIL_IRQ_RISE_BIT] = 1'b1;
		end
		if (primed && (slew_sync != slew_prev_ff)) begin
			nxt_irq_stat[`PSIL_IRQ_SLEW_BIT] = 1'b1;
		end
		nxt_irq = |(nxt_irq_stat & nxt_irq_mask);
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			prev_ff      <= `PSIL_RST_BYTE;
			slew_prev_ff <= 4'h0;
			primed_ff    <= 3'b000;
			flags_ff     <= `PSIL_RST_BYTE;
			mask_ff      <= `PSIL_RST_BYTE;
			pol_ff       <= `PSIL_RST_BYTE;
			ctl_ff       <= `PSIL_RST_BYTE;
			stat_ff      <= `PSIL_RST_BYTE;
			int_ff       <= 1'b0;
			irq_stat_ff  <= `PSIL_RST_BYTE;
			irq_mask_ff  <= `PSIL_RST_BYTE;
			irq_ff       <= 1'b0;
		end else begin
			prev_ff      <= nxt_prev;
			slew_prev_ff <= nxt_slew_prev;
			primed_ff    <= nxt_primed;
			flags_ff     <= nxt_flags;
			mask_ff      <= nxt_mask;
			pol_ff       <= nxt_pol;
			ctl_ff       <= nxt_ctl;
			stat_ff      <= nxt_stat;
			int_ff       <= nxt_int;
			irq_stat_ff  <= nxt_irq_stat;
			irq_mask_ff  <= nxt_irq_mask;
			irq_ff       <= nxt_irq;
		end
	end

	assign irq = irq_ff;

	// ****************************************************************
	// Assertions
	// ****************************************************************
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (srst);

	flag_latch_a: assert property (
		(flag_set != 8'h00) |=> ((flags_ff & $past(flag_set)) == $past(flag_set)))
		else $error("edge did not latch its flag");

	flag_order_a: assert property (
		(en && edge_hit == 8'h80 && !flag_wr) |=>
		(flags_ff == ($past(flags_ff) | 8'h80)))
		else $error("top source did not land on bit 7");

	flag_clear_a: assert property (
		(flag_wr && flag_set == 8'h00) |=>
		(flags_ff == ($past(flags_ff) & $past(wdata8))))
		else $error("write of zero did not clear only its flag");

	flag_sticky_a: assert property (
		!flag_wr |=> ((flags_ff & $past(flags_ff)) == $past(flags_ff)))
		else $error("flag dropped without a clearing write");

	no_latch_off_a: assert property (
		(!en && !flag_wr) |=> $stable(flags_ff))
		else $error("flags changed while disabled");

	and_combine_a: assert property (
		(en && and_mode && and_int) |=> int_ff)
		else $error("AND combination missed");

	or_combine_a: assert property (
		(en && !and_mode) |=> (int_ff == $past(or_int)))
		else $error("OR combination wrong");

	mask_excl_a: assert property (
		(en && !and_mode && act_or == 8'h00) |=> !int_ff)
		else $error("masked flag raised the interrupt");

	pins_quiet_a: assert property (
		(!en)[*2] |-> !pin_a_level)
		else $error("status pin active while disabled");

	live_view_a: assert property (
		(req.valid && !req.write && req.index == `PSIL_IDX_LIVE) |=>
		(hrdata[7:0] == $past(src_live)))
		else $error("live view read wrong");

	slew_view_a: assert property (
		(req.valid && !req.write && req.index == `PSIL_IDX_SLEW) |=>
		(hrdata == {24'h00_0000, $past(slew_word)}))
		else $error("slew indicator read wrong");

	open_drain_a: assert property (
		stat_ff[`PSIL_STAT_OD_B] |-> (!status_out_b && status_out_b_oe == !int_ff))
		else $error("open drain drive wrong");

	spike_cfg_a: assert property (
		(req.valid && req.write && req.index == `PSIL_IDX_STAT) |=>
		(status_out_a_spike_limit == $past(req.wdata[`PSIL_STAT_SL_A])))
		else $error("spike limit setting not applied");

	rise_edge_a: assert property (
		(primed && $rose(src_live[0]) && pol_ff[0] && en) |=> flags_ff[0])
		else $error("rising edge missed");

	los_first_a: assert property (
		src_sync[`PSIL_SRC_LOS_A] |-> !src_live[`PSIL_SRC_LOL_A])
		else $error("lock loss shown with input loss");

	edge_cmp_a: assert property (
		(edge_hit != 8'h00) |-> ((src_live ^ prev_ff) != 8'h00))
		else $error("edge without a change of sample");

	flag_or_c: cover property (en && !and_mode && int_now && !int_ff);
	flag_and_c: cover property (en && and_mode && and_int);
	od_pin_c: cover property (stat_ff[`PSIL_STAT_OD_A] && int_ff);
	irq_out_c: cover property ($rose(irq));
endmodule

`default_nettype wire

// ---- rtl/psil_defs.svh ----
`ifndef PSIL_DEFS_SVH
`define PSIL_DEFS_SVH

// ****************************************************************
// Register indexes (byte address is four times the index)
// ****************************************************************
`define PSIL_IDX_LIVE      8'h0D
`define PSIL_IDX_MASK      8'h0E
`define PSIL_IDX_POL       8'h0F
`define PSIL_IDX_FLAGS     8'h10
`define PSIL_IDX_CTL       8'h11
`define PSIL_IDX_SLEW      8'h12
`define PSIL_IDX_STAT      8'h13
`define PSIL_IDX_IRQ_STAT  8'h20
`define PSIL_IDX_IRQ_MASK  8'h21

// ****************************************************************
// Reset values and writable bits
// ****************************************************************
`define PSIL_RST_BYTE      8'h00
`define PSIL_ALL_ONES      8'hFF
`define PSIL_CTL_RW_MASK   8'h03
`define PSIL_STAT_RW_MASK  8'h3F
`define PSIL_IRQ_RW_MASK   8'h03

// ****************************************************************
// Field positions
// ****************************************************************
`define PSIL_CTL_EN_BIT    0
`define PSIL_CTL_AND_BIT   1
`define PSIL_STAT_OD_A     0
`define PSIL_STAT_OD_B     1
`define PSIL_STAT_SL_A     4
`define PSIL_STAT_SL_B     5
`define PSIL_SRC_LOL_A     7
`define PSIL_SRC_LOS_A     6
`define PSIL_SRC_LOL_B     4
`define PSIL_SRC_LOS_B     3
`define PSIL_IRQ_RISE_BIT  0
`define PSIL_IRQ_SLEW_BIT  1

// ****************************************************************
// Bus decode
// ****************************************************************
`define PSIL_ADDR_IDX_LSB  2
`define PSIL_ADDR_IDX_MSB  9
`define PSIL_ADDR_HI_LSB   10

`endif

// ---- rtl/psil_pkg.sv ----
package psil_pkg;

	// Bit 7 first, in flag order
	typedef struct packed {
		logic pll_a_lock_lost;
		logic pll_a_input_lost;
		logic pll_a_vco_calibrating;
		logic pll_b_lock_lost;
		logic pll_b_input_lost;
		logic pll_b_vco_calibrating;
		logic pll_a_fallback_return;
		logic pll_b_fallback_return;
	} psil_src_s;

	typedef struct packed {
		logic second_ref_rise_ok;
		logic second_ref_fall_ok;
		logic main_ref_rise_ok;
		logic main_ref_fall_ok;
	} psil_slew_s;

	typedef struct packed {
		logic        valid;
		logic        write;
		logic [7:0]  index;
		logic [31:0] wdata;
	} psil_req_s;

	typedef enum logic [1:0] {
		PSIL_PH_IDLE = 2'b00,
		PSIL_PH_WAIT = 2'b01,
		PSIL_PH_DONE = 2'b10
	} psil_phase_e;

	typedef logic [7:0] psil_byte_t;

endpackage

// ---- rtl/psil_sync.sv ----
`timescale 1ns/10ps
`default_nettype none

module psil_sync #(
	parameter int WIDTH = 8
) (
	input  wire logic             core_clk,
	input  wire logic             srst,
	input  wire logic [WIDTH-1:0] d,
	output logic      [WIDTH-1:0] q
);
	logic [WIDTH-1:0] meta_ff;
	logic [WIDTH-1:0] sync_ff;
	logic [WIDTH-1:0] nxt_meta;
	logic [WIDTH-1:0] nxt_sync;

	always_comb begin
		nxt_meta = d;
		nxt_sync = meta_ff;
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			meta_ff <= '0;
			sync_ff <= '0;
		end else begin
			meta_ff <= nxt_meta;
			sync_ff <= nxt_sync;
		end
	end

	assign q = sync_ff;
endmodule

`default_nettype wire

// ---- rtl/psil_ahb_slave.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "psil_defs.svh"

module psil_ahb_slave (
	input  wire logic              core_clk,
	input  wire logic              srst,
	input  wire logic              hsel,
	input  wire logic [31:0]       haddr,
	input  wire logic [1:0]        htrans,
	input  wire logic              hwrite,
	input  wire logic [2:0]        hsize,
	input  wire logic [31:0]       hwdata,
	input  wire logic              hready,
	output logic                   hreadyout,
	output logic                   hresp,
	output logic      [31:0]       hrdata,
	output psil_pkg::psil_req_s    req,
	input  wire logic [31:0]       rdata
);
	import psil_pkg::*;

	psil_phase_e ph_ff;
	psil_phase_e nxt_ph;
	logic        wr_ff;
	logic        nxt_wr;
	logic        hit_ff;
	logic        nxt_hit;
	logic [7:0]  idx_ff;
	logic [7:0]  nxt_idx;
	logic [31:0] rd_ff;
	logic [31:0] nxt_rd;
	logic        accept;
	logic        unused_size;

	// ****************************************************************
	// Address phase capture, one wait state in the data phase
	// ****************************************************************
	assign accept = hsel && htrans[1] && hready;
	assign unused_size = ^hsize;

	always_comb begin
		nxt_ph  = ph_ff;
		nxt_wr  = wr_ff;
		nxt_hit = hit_ff;
		nxt_idx = idx_ff;
		nxt_rd  = rd_ff;
		case (ph_ff)
			PSIL_PH_IDLE, PSIL_PH_DONE: begin
				nxt_ph = PSIL_PH_IDLE;
				if (accept) begin
					nxt_ph  = PSIL_PH_WAIT;
					nxt_wr  = hwrite;
					nxt_hit = (haddr[31:`PSIL_ADDR_HI_LSB] == '0);
					nxt_idx = haddr[`PSIL_ADDR_IDX_MSB:`PSIL_ADDR_IDX_LSB];
				end
			end
			PSIL_PH_WAIT: begin
				nxt_ph = PSIL_PH_DONE;
				nxt_rd = (!wr_ff && hit_ff) ? rdata : 32'h0000_0000;
			end
			default: nxt_ph = PSIL_PH_IDLE;
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			ph_ff  <= PSIL_PH_IDLE;
			wr_ff  <= 1'b0;
			hit_ff <= 1'b0;
			idx_ff <= 8'h00;
			rd_ff  <= 32'h0000_0000;
		end else begin
			ph_ff  <= nxt_ph;
			wr_ff  <= nxt_wr;
			hit_ff <= nxt_hit;
			idx_ff <= nxt_idx;
			rd_ff  <= nxt_rd;
		end
	end

	assign hreadyout = (ph_ff != PSIL_PH_WAIT);
	assign hresp     = 1'b0;
	assign hrdata    = rd_ff;

	always_comb begin
		req.valid = (ph_ff == PSIL_PH_WAIT) && hit_ff;
		req.write = wr_ff;
		req.index = idx_ff;
		req.wdata = hwdata;
	end
endmodule

`default_nettype wire

// ---- tb/psil_host_model.sv ----
`timescale 1ns/10ps
`default_nettype none

// ****************************************************************
// Host side of the two status pins, each with a pull-up
// ****************************************************************
module psil_host_model (
	input  wire logic status_out_a,
	input  wire logic status_out_a_oe,
	input  wire logic status_out_b,
	input  wire logic status_out_b_oe,
	output logic      pin_a_level,
	output logic      pin_b_level
);
	// A released pin floats up to the pull-up level
	assign pin_a_level = status_out_a_oe ? status_out_a : 1'b1;
	assign pin_b_level = status_out_b_oe ? status_out_b : 1'b1;
endmodule

`default_nettype wire

// ---- tb/pll_status_interrupt_logic_bench.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "psil_defs.svh"

module pll_status_interrupt_logic_bench;
	import psil_pkg::*;

`define CHECK_EQ(got, exp) \
	begin \
		samples_checked++; \
		if ((got) !== (exp)) begin \
			err_total++; \
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp); \
		end \
	end

	logic        core_clk, srst, hsel, hwrite;
	logic [31:0] haddr, hwdata, hrdata, rd;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	logic        hreadyout, hresp, irq;
	logic        sa, sa_oe, sb, sb_oe, sl_a, sl_b, pin_a, pin_b;
	psil_src_s   src_raw;
	psil_slew_s  slew_raw;
	int          err_total, samples_checked, cycles;

	psil_top dut_u (
		.core_clk(core_clk), .srst(srst), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize),
		.hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
		.hresp(hresp), .hrdata(hrdata), .src_raw(src_raw),
		.slew_raw(slew_raw), .status_out_a(sa), .status_out_a_oe(sa_oe),
		.status_out_b(sb), .status_out_b_oe(sb_oe),
		.status_out_a_spike_limit(sl_a), .status_out_b_spike_limit(sl_b),
		.irq(irq)
	);

	psil_host_model host_u (
		.status_out_a(sa), .status_out_a_oe(sa_oe), .status_out_b(sb),
		.status_out_b_oe(sb_oe), .pin_a_level(pin_a), .pin_b_level(pin_b)
	);

	// ****************************************************************
	// Clock, timeout and verdict
	// ****************************************************************
	initial begin
		core_clk = 1'b0;
		forever #2 core_clk = ~core_clk;
	end

	task automatic close_out();
		$display("Comparisons %0d, mismatches %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 4000) begin
			err_total++;
			close_out();
		end
	end

	// ****************************************************************
	// Bus tasks
	// ****************************************************************
	task automatic tick(input int n);
		repeat (n) @(posedge core_clk);
	endtask

	// Address phase held until hready, then data phase until hready
	task automatic xfer(input logic wr, input logic [7:0] idx,
			input logic [7:0] wd, output logic [31:0] rdv);
		hsel   <= 1'b1;
		htrans <= 2'b10;
		hwrite <= wr;
		haddr  <= {22'h000000, idx, 2'b00};
		do @(posedge core_clk); while (hreadyout !== 1'b1);
		htrans <= 2'b00;
		hwdata <= {24'h000000, wd};
		do @(posedge core_clk); while (hreadyout !== 1'b1);
		rdv = hrdata;
	endtask

	task automatic wr(input logic [7:0] idx, input logic [7:0] wd);
		logic [31:0] dummy;
		xfer(1'b1, idx, wd, dummy);
	endtask

	task automatic chk_reg(input logic [7:0] idx, input logic [7:0] exp);
		xfer(1'b0, idx, 8'h00, rd);
		`CHECK_EQ(rd, {24'h000000, exp})
		`CHECK_EQ(hresp, 1'b0)
	endtask

	task automatic chk_pins(input logic lvl);
		`CHECK_EQ({pin_b, pin_a}, {lvl, lvl})
	endtask

	// ****************************************************************
	// Test sequence
	// ****************************************************************
	initial begin
		srst = 1'b1;
		hsel = 1'b0;
		htrans = 2'b00;
		hwrite = 1'b0;
		hsize = 3'b010;
		haddr = 32'h00000000;
		hwdata = 32'h00000000;
		src_raw = 8'h00;
		slew_raw = 4'h0;
		err_total = 0;
		samples_checked = 0;
		cycles = 0;
		tick(8);
		srst <= 1'b0;
		tick(2);
		chk_reg(`PSIL_IDX_FLAGS, 8'h00);
		chk_reg(`PSIL_IDX_CTL, 8'h00);
		chk_reg(`PSIL_IDX_STAT, 8'h00);
		wr(`PSIL_IDX_CTL, 8'hFF);
		chk_reg(`PSIL_IDX_CTL, 8'h03);
		wr(`PSIL_IDX_CTL, 8'h00);
		wr(`PSIL_IDX_STAT, 8'hFF);
		chk_reg(`PSIL_IDX_STAT, 8'h3F);
		wr(`PSIL_IDX_STAT, 8'h00);
		wr(8'h3F, 8'h5A);
		chk_reg(8'h3F, 8'h00);
		// Edges while disabled: live view moves, flags do not
		wr(`PSIL_IDX_POL, 8'hDB);
		src_raw <= 8'hDB;
		tick(6);
		chk_reg(`PSIL_IDX_LIVE, 8'h4B);
		chk_reg(`PSIL_IDX_FLAGS, 8'h00);
		chk_pins(1'b0);
		src_raw <= 8'h24;
		tick(6);
		wr(`PSIL_IDX_CTL, 8'h01);
		// One qualifying edge per source, bit 7 first
		for (int i = 7; i >= 0; i--) begin
			src_raw[i] <= ~src_raw[i];
			tick(6);
			chk_reg(`PSIL_IDX_FLAGS, 8'hFF << i);
		end
		chk_pins(1'b1);
		wr(`PSIL_IDX_CTL, 8'h03);
		tick(3);
		chk_pins(1'b1);
		wr(`PSIL_IDX_FLAGS, 8'h7F);
		chk_reg(`PSIL_IDX_FLAGS, 8'h7F);
		chk_pins(1'b0);
		wr(`PSIL_IDX_MASK, 8'h80);
		tick(3);
		chk_pins(1'b1);
		wr(`PSIL_IDX_CTL, 8'h00);
		tick(3);
		chk_pins(1'b0);
		wr(`PSIL_IDX_CTL, 8'h01);
		wr(`PSIL_IDX_MASK, 8'hFF);
		tick(3);
		chk_pins(1'b0);
		wr(`PSIL_IDX_MASK, 8'h00);
		wr(`PSIL_IDX_STAT, 8'h33);
		tick(3);
		chk_pins(1'b1);
		`CHECK_EQ({sb_oe, sa_oe}, 2'b00)
		`CHECK_EQ({sl_b, sl_a}, 2'b11)
		wr(`PSIL_IDX_FLAGS, 8'h00);
		tick(3);
		chk_reg(`PSIL_IDX_FLAGS, 8'h00);
		chk_pins(1'b0);
		`CHECK_EQ({sb_oe, sa_oe}, 2'b11)
		wr(`PSIL_IDX_STAT, 8'h00);
		// Opposite edges must not latch
		src_raw <= 8'h24;
		tick(6);
		chk_reg(`PSIL_IDX_FLAGS, 8'h00);
		// Edges lost while disabled stay lost
		wr(`PSIL_IDX_CTL, 8'h00);
		src_raw <= 8'hDB;
		tick(6);
		wr(`PSIL_IDX_CTL, 8'h01);
		tick(6);
		chk_reg(`PSIL_IDX_FLAGS, 8'h00);
		// Interrupt status, mask and read clear
		xfer(1'b0, `PSIL_IDX_IRQ_STAT, 8'h00, rd);
		wr(`PSIL_IDX_IRQ_MASK, 8'h03);
		slew_raw <= 4'hA;
		tick(6);
		`CHECK_EQ(irq, 1'b1)
		chk_reg(`PSIL_IDX_SLEW, 8'hA0);
		chk_reg(`PSIL_IDX_IRQ_STAT, 8'h02);
		tick(2);
		`CHECK_EQ(irq, 1'b0)
		wr(`PSIL_IDX_IRQ_MASK, 8'h00);
		slew_raw <= 4'h5;
		tick(6);
		`CHECK_EQ(irq, 1'b0)
		chk_reg(`PSIL_IDX_IRQ_STAT, 8'h02);
		wr(`PSIL_IDX_IRQ_MASK, 8'h01);
		src_raw[0] <= 1'b0;
		tick(3);
		src_raw[0] <= 1'b1;
		tick(8);
		`CHECK_EQ(irq, 1'b1)
		chk_reg(`PSIL_IDX_IRQ_STAT, 8'h01);
		close_out();
	end
endmodule

`default_nettype wire
